// File: rtl/vector_priority_map.sv
// Purpose: vector table, priority pick and watchdog service location
// Assumes: apb byte addresses, low 16 bits name the device address
// Notes:   vector contents are written over apb, undefined bytes read 83
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module vector_priority_map
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] irq_src,
    input  wire logic        trap_req,
    input  wire logic        fetch_req,
    output logic [15:0]      fetch_vector,
    output logic [4:0]       fetch_slot,
    output logic             irq_pending,
    output logic             watchdog_timeout,
    output logic             irq
);
    typedef struct packed {
        logic [51:0][7:0] table_b;
        logic [51:0]      defined;
        logic [23:0]      status;
        logic [23:0]      enable;
        logic [15:0]      wdog;
        logic             wdog_to;
        logic [15:0]      fvec;
        logic [4:0]       fslot;
        logic [31:0]      rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic        sel_any;
    logic [4:0]  sel_slot;
    logic [23:0] masked;

    function automatic logic in_vec(input logic [15:0] a);
        in_vec = (a >= vector_map_pkg::VEC_BASE);
    endfunction

    function automatic logic [5:0] vidx(input logic [15:0] a);
        logic [15:0] d;
        d    = a - vector_map_pkg::VEC_BASE;
        vidx = d[5:0];
    endfunction

    function automatic logic [7:0] vbyte(input state_t s, input logic [5:0] i);
        vbyte = s.defined[i] ? s.table_b[i] : vector_map_pkg::TRAP_OPCODE;
    endfunction

    // own control registers, used by the error decode only
    function automatic logic own_reg(input logic [15:0] a);
        own_reg = (a == vector_map_pkg::REG_STATUS)
               || (a == vector_map_pkg::REG_CLEAR)
               || (a == vector_map_pkg::REG_ENABLE)
               || (a == vector_map_pkg::REG_ACTIVE)
               || (a == vector_map_pkg::REG_WDOG_CNT)
               || (a == vector_map_pkg::REG_DEFINED);
    endfunction

    assign masked = st_r.status & st_r.enable;

    vector_slot_select u_sel
    (
        .pending (masked),
        .any     (sel_any),
        .slot    (sel_slot)
    );

    logic        acc;
    logic        wr;
    logic        rd;
    logic [15:0] a16;
    logic        hi_bits_ok;
    logic        rd_setup;
    logic        sw_mask_wr;
    assign acc        = psel && penable;
    assign wr         = acc && pwrite;
    assign rd         = acc && !pwrite;
    assign a16        = paddr[15:0];
    assign hi_bits_ok = (paddr[31:16] == 16'h0000);
    // read data is loaded at setup so it stands at the access edge
    assign rd_setup   = psel && !penable && !pwrite;
    assign sw_mask_wr = wr && hi_bits_ok && (a16 == vector_map_pkg::REG_CLEAR
                     || a16 == vector_map_pkg::REG_ENABLE);

    always_comb
    begin
        logic [5:0] hi;
        logic       mapped;
        hi     = 6'h00;
        mapped = 1'b0;
        st_nxt = st_r;
        st_nxt.rdata = 32'h00000000;
        // sticky capture, set wins over clear
        if (wr && hi_bits_ok && a16 == vector_map_pkg::REG_CLEAR)
        begin
            st_nxt.status = st_r.status & ~pwdata[23:0];
        end
        st_nxt.status = st_nxt.status | irq_src;
        // watchdog free count, saturates at timeout
        if (st_r.wdog != vector_map_pkg::WDOG_LIMIT)
        begin
            st_nxt.wdog = st_r.wdog + 16'h0001;
        end
        else
        begin
            st_nxt.wdog_to = 1'b1;
        end
        if (wr && hi_bits_ok && a16 == vector_map_pkg::WDOG_LOC)
        begin
            st_nxt.wdog    = 16'h0000;
            st_nxt.wdog_to = 1'b0;
        end
        // top range holds vector bytes only
        if (hi_bits_ok && in_vec(a16))
        begin
            mapped = 1'b1;
            if (wr && a16 != vector_map_pkg::WDOG_LOC)
            begin
                st_nxt.table_b[vidx(a16)] = pwdata[7:0];
                st_nxt.defined[vidx(a16)] = 1'b1;
            end
            // reset vector low byte, never watchdog
            if (rd_setup)
            begin
                st_nxt.rdata = {24'h000000, vbyte(st_r, vidx(a16))};
            end
        end
        // own registers kept below vector range
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_STATUS)
        begin
            mapped = 1'b1;
            st_nxt.rdata = {8'h00, st_r.status};
        end
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_CLEAR)
        begin
            mapped = 1'b1;
        end
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_ENABLE)
        begin
            mapped = 1'b1;
            if (wr)
            begin
                st_nxt.enable = pwdata[23:0];
            end
            st_nxt.rdata = {8'h00, st_r.enable};
        end
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_ACTIVE)
        begin
            mapped = 1'b1;
            st_nxt.rdata = {23'h000000, st_r.wdog_to, sel_any, 2'h0, sel_slot};
        end
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_WDOG_CNT)
        begin
            mapped = 1'b1;
            st_nxt.rdata = {16'h0000, st_r.wdog};
        end
        else if (hi_bits_ok && a16 == vector_map_pkg::REG_DEFINED)
        begin
            mapped = 1'b1;
            st_nxt.rdata = {6'h00, st_r.defined[51:26]};
        end
        // loaded at setup, held through access, zero otherwise
        if (!(mapped && rd_setup))
        begin
            st_nxt.rdata = 32'h00000000;
        end
        if (rd)
        begin
            st_nxt.rdata = st_r.rdata;
        end
        if (fetch_req)
        begin
            // trap above sources above reset slot
            if (trap_req)
            begin
                st_nxt.fslot = vector_map_pkg::TRAP_SLOT;
            end
            else if (sel_any)
            begin
                st_nxt.fslot = sel_slot;
            end
            else
            begin
                st_nxt.fslot = vector_map_pkg::RESET_SLOT;
            end
            // high byte even, low byte odd
            hi = {st_nxt.fslot, 1'b0};
            st_nxt.fvec = {vbyte(st_r, hi), vbyte(st_r, hi + 6'h01)};
        end
    end

    logic unmapped;
    assign unmapped = !(hi_bits_ok && (in_vec(a16) || own_reg(a16)));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.enable <= vector_map_pkg::ENABLE_RESET[23:0];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // zero wait state slave
    assign pready           = 1'b1;
    assign pslverr          = acc && unmapped;
    assign prdata           = st_r.rdata;
    assign fetch_vector     = st_r.fvec;
    assign fetch_slot       = st_r.fslot;
    assign irq_pending      = sel_any;
    assign watchdog_timeout = st_r.wdog_to;
    assign irq              = |masked;

    // apb read phases used by the checks below
    sequence s_setup_read;
        psel && !penable && !pwrite && hi_bits_ok;
    endsequence
    sequence s_access_read;
        psel && penable && !pwrite;
    endsequence
    sequence s_read_pair;
        s_setup_read ##1 s_access_read;
    endsequence

    a_wdog_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a16 == vector_map_pkg::WDOG_LOC && hi_bits_ok) |=> (st_r.wdog == 16'h0000))
        else $error("watchdog not cleared by write");
    a_pick_enabled: assert property (@(posedge pclk) disable iff (!presetn)
        sel_any |-> masked[sel_slot])
        else $error("selected slot not pending");
    a_pick_highest: assert property (@(posedge pclk) disable iff (!presetn)
        sel_any |-> ((masked >> sel_slot) >> 1) == 24'h000000)
        else $error("higher pending slot ignored");
    a_undef_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && hi_bits_ok && in_vec(a16) && !st_r.defined[vidx(a16)])
        |=> (prdata == {24'h000000, vector_map_pkg::TRAP_OPCODE}))
        else $error("undefined vector byte wrong");
    a_no_table_wdog: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hi_bits_ok && a16 == vector_map_pkg::WDOG_LOC)
        |=> $stable(st_r.table_b[51]))
        else $error("watchdog write altered reset vector");
    a_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
        (|irq_src) |=> ((st_r.status & $past(irq_src)) == $past(irq_src)))
        else $error("event lost");
    // irq drops only on software write
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(irq) |-> $past(sw_mask_wr))
        else $error("irq dropped without software write");
    a_fetch_trap: assert property (@(posedge pclk) disable iff (!presetn)
        (fetch_req && trap_req) |=> (fetch_slot == vector_map_pkg::TRAP_SLOT))
        else $error("trap slot not fetched");
    a_vec_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_pair ##0 in_vec(a16)) |-> (prdata[31:8] == 24'h000000))
        else $error("vector read has upper bits set");
    a_wdog_read: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_pair ##0 (a16 == vector_map_pkg::WDOG_LOC))
        |-> (prdata[7:0] == vbyte(st_r, vidx(vector_map_pkg::WDOG_LOC))))
        else $error("watchdog location read wrong");
    a_fetch_pick: assert property (@(posedge pclk) disable iff (!presetn)
        (fetch_req && !trap_req && sel_any) |=> (fetch_slot == $past(sel_slot)))
        else $error("fetch slot differs from pick");
    a_fetch_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (fetch_req && !trap_req && !sel_any) |=> (fetch_slot == vector_map_pkg::RESET_SLOT))
        else $error("reset slot not fetched");
    a_clear_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hi_bits_ok && a16 == vector_map_pkg::REG_CLEAR && irq_src == 24'h000000)
        |=> ((st_r.status & 24'($past(pwdata))) == 24'h000000))
        else $error("status clear ignored");
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hi_bits_ok && a16 == vector_map_pkg::REG_ENABLE)
        |=> (st_r.enable == 24'($past(pwdata))))
        else $error("enable write lost");
    a_wdog_count: assert property (@(posedge pclk) disable iff (!presetn)
        (!(wr && hi_bits_ok && a16 == vector_map_pkg::WDOG_LOC)
            && st_r.wdog != vector_map_pkg::WDOG_LIMIT)
        |=> (st_r.wdog == $past(st_r.wdog) + 16'h0001))
        else $error("watchdog count stalled");
    a_timeout_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.wdog_to && !(wr && hi_bits_ok && a16 == vector_map_pkg::WDOG_LOC))
        |=> st_r.wdog_to)
        else $error("watchdog timeout dropped");
    a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !hi_bits_ok) |=> ($stable(st_r.table_b) && $stable(st_r.enable)))
        else $error("refused write changed state");
    a_vec_no_error: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && hi_bits_ok && in_vec(a16)) |-> !pslverr)
        else $error("vector access flagged as error");
    a_vec_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hi_bits_ok && in_vec(a16) && a16 != vector_map_pkg::WDOG_LOC)
        |=> (st_r.table_b[vidx($past(a16))] == 8'($past(pwdata))))
        else $error("vector byte not stored");
    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (s_setup_read ##0 (a16 == vector_map_pkg::REG_STATUS))
        |=> (prdata == {8'h00, $past(st_r.status)}))
        else $error("status read wrong");
    a_fetch_bytes: assert property (@(posedge pclk) disable iff (!presetn)
        (fetch_req && trap_req && !wr)
        |=> (fetch_vector == {vbyte(st_r, {vector_map_pkg::TRAP_SLOT, 1'b0}),
                              vbyte(st_r, {vector_map_pkg::TRAP_SLOT, 1'b1})}))
        else $error("trap vector bytes wrong");
endmodule

// File: rtl/vector_map_pkg.sv
// Purpose: constants for the vector priority map
// Assumes: 16-bit device address space carried in apb byte address
// Notes:   vector table occupies the top 52 bytes
package vector_map_pkg;
    localparam logic [15:0] VEC_BASE        = 16'hFFCC;
    localparam logic [15:0] VEC_TOP         = 16'hFFFF;
    localparam logic [15:0] SCR_BASE        = 16'hFE00;
    localparam logic [15:0] SCR_TOP         = 16'hFFCB;
    localparam logic [15:0] WDOG_LOC        = 16'hFFFF;
    localparam logic [7:0]  TRAP_OPCODE     = 8'h83;
    localparam int          NUM_VEC         = 26;
    localparam int          NUM_SRC         = 24;
    localparam logic [4:0]  TRAP_SLOT       = 5'h18;
    localparam logic [4:0]  RESET_SLOT      = 5'h19;
    // register window for the block's own controls, inside fe00..ffcb
    localparam logic [15:0] REG_STATUS      = 16'hFF80;
    localparam logic [15:0] REG_CLEAR       = 16'hFF84;
    localparam logic [15:0] REG_ENABLE      = 16'hFF88;
    localparam logic [15:0] REG_ACTIVE      = 16'hFF8C;
    localparam logic [15:0] REG_WDOG_CNT    = 16'hFF90;
    localparam logic [15:0] REG_DEFINED     = 16'hFF94;
    localparam logic [31:0] ENABLE_RESET    = 32'h00000000;
    localparam logic [15:0] WDOG_LIMIT      = 16'hFFFF;
endpackage

// File: rtl/vector_slot_select.sv
// Purpose: fixed priority pick of the highest pending source
// Assumes: bit index equals slot index, higher index wins
// Notes:   purely combinational
`timescale 1ns/10ps
module vector_slot_select
(
    input  wire logic [23:0] pending,
    output logic             any,
    output logic [4:0]       slot
);
    always_comb
    begin
        any  = 1'b0;
        slot = 5'h00;
        for (int i = 0; i < vector_map_pkg::NUM_SRC; i++)
        begin
            if (pending[i])
            begin
                any  = 1'b1;
                slot = 5'(i);
            end
        end
    end
endmodule

// File: dv/core_model.sv
// Purpose: processor core stand-in that fetches interrupt vectors
// Assumes: fetch result is registered one cycle after the request
// Notes:   trap level is held only across its own fetch
`timescale 1ns/10ps
module core_model
(
    input  wire logic        pclk,
    output logic             fetch_req,
    output logic             trap_req,
    input  wire logic [15:0] fetch_vector,
    input  wire logic [4:0]  fetch_slot
);
    initial
    begin
        fetch_req = 1'b0;
        trap_req  = 1'b0;
    end

    task automatic fetch(input logic trap, output logic [4:0] slot, output logic [15:0] vec);
        begin
            @(posedge pclk);
            trap_req  <= trap;
            fetch_req <= 1'b1;
            @(posedge pclk);
            fetch_req <= 1'b0;
            trap_req  <= 1'b0;
            // registered at the pulse edge, taken one edge later
            @(posedge pclk);
            slot = fetch_slot;
            vec  = fetch_vector;
        end
    endtask
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the vector priority map
// Assumes: apb master, zero or more wait states
// Notes:   vector bytes stand in for program memory
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic [23:0] irq_src;
    logic        fetch_req, trap_req, irq_pending, watchdog_timeout, irq, errv;
    logic [15:0] fetch_vector, gv;
    logic [4:0]  fetch_slot, gs;
    int          n_mismatch, tests_run, cyc, k;

    vector_priority_map uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_src(irq_src),
        .trap_req(trap_req), .fetch_req(fetch_req), .fetch_vector(fetch_vector),
        .fetch_slot(fetch_slot), .irq_pending(irq_pending),
        .watchdog_timeout(watchdog_timeout), .irq(irq));
    core_model core (.pclk(pclk), .fetch_req(fetch_req), .trap_req(trap_req),
        .fetch_vector(fetch_vector), .fetch_slot(fetch_slot));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic tally_and_finish();
        begin
            if (n_mismatch == 0 && tests_run > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // a hang ends the run as a failure
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            // response taken at the edge that sees pready
            errv = pslverr;
            rdv  = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask

    task automatic pulse(input logic [23:0] s);
        begin
            @(posedge pclk);
            irq_src <= s;
            @(posedge pclk);
            irq_src <= 24'h000000;
            @(posedge pclk);
            #1;
        end
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_src} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 26; k += 12)
        begin
            apb(1'b0, {16'h0000, 16'hFFCC + {k[14:0], 1'b0}}, 32'h0);
            `CHK(rdv[7:0], vector_map_pkg::TRAP_OPCODE)
        end
        // slots 0 to 24 and byte fffe defined, reset low byte falls to trap
        for (k = 0; k < 25; k++)
        begin
            apb(1'b1, {16'h0000, 16'hFFCC + {k[14:0], 1'b0}}, {24'h0, 8'h10 + k[7:0]});
            apb(1'b1, {16'h0000, 16'hFFCD + {k[14:0], 1'b0}}, {24'h0, 8'h80 + k[7:0]});
        end
        apb(1'b1, 32'h0000FFFE, 32'h0000007E);
        apb(1'b1, 32'h0000FFFF, 32'h00000055);
        apb(1'b0, {16'h0000, vector_map_pkg::REG_WDOG_CNT}, 32'h0);
        `CHK(rdv < 32'h00000010, 1'b1)
        `CHK(watchdog_timeout, 1'b0)
        apb(1'b0, {16'h0000, vector_map_pkg::REG_DEFINED}, 32'h0);
        `CHK(rdv, 32'h01FFFFFF)
        apb(1'b1, 32'h0001FFCC, 32'h000000EE);
        `CHK(errv, 1'b1)
        for (k = 0; k < 25; k++)
        begin
            apb(1'b0, {16'h0000, 16'hFFCC + {k[14:0], 1'b0}}, 32'h0);
            `CHK(rdv[7:0], 8'h10 + k[7:0])
            apb(1'b0, {16'h0000, 16'hFFCD + {k[14:0], 1'b0}}, 32'h0);
            `CHK(rdv[7:0], 8'h80 + k[7:0])
        end
        apb(1'b0, 32'h0000FFFF, 32'h0);
        `CHK(rdv[7:0], vector_map_pkg::TRAP_OPCODE)
        apb(1'b1, {16'h0000, vector_map_pkg::REG_ENABLE}, 32'h00FFFFFF);
        // lowest slot pending beside each higher one
        for (k = 0; k < 24; k++)
        begin
            apb(1'b1, {16'h0000, vector_map_pkg::REG_CLEAR}, 32'h00FFFFFF);
            pulse((24'h000001 << k) | 24'h000001);
            `CHK(irq, 1'b1)
            core.fetch(1'b0, gs, gv);
            `CHK(gs, k[4:0])
            `CHK(gv, {8'h10 + k[7:0], 8'h80 + k[7:0]})
        end
        apb(1'b0, {16'h0000, vector_map_pkg::REG_ACTIVE}, 32'h0);
        `CHK(rdv, 32'h00000097)
        core.fetch(1'b1, gs, gv);
        `CHK(gs, vector_map_pkg::TRAP_SLOT)
        `CHK(gv, {8'h28, 8'h98})
        apb(1'b1, {16'h0000, vector_map_pkg::REG_CLEAR}, 32'h00FFFFFF);
        core.fetch(1'b0, gs, gv);
        `CHK(gv, {8'h7E, vector_map_pkg::TRAP_OPCODE})
        `CHK(gs, vector_map_pkg::RESET_SLOT)
        apb(1'b1, {16'h0000, vector_map_pkg::REG_ENABLE}, 32'h0);
        pulse(24'h000020);
        `CHK(irq_pending, 1'b0)
        apb(1'b0, {16'h0000, vector_map_pkg::REG_STATUS}, 32'h0);
        `CHK(rdv[5], 1'b1)
        apb(1'b1, {16'h0000, vector_map_pkg::REG_ENABLE}, 32'h00000020);
        `CHK(irq, 1'b1)
        apb(1'b1, {16'h0000, vector_map_pkg::REG_CLEAR}, 32'h00000020);
        `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule
